// >>> hw/pin_edge_sync.sv
/*
  Two-flop synchroniser with activation pulse for an active-low pin.
  Assumes the pin is asynchronous to the clock.
*/
`timescale 1ns/1ps
module pin_edge_sync
  import wdt_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin_n,
  output logic active,
  output logic activated
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } sync_t;
  sync_t st_q, st_d;

  // Shift chain; first stage feeds only the second
  always_comb
  begin
    st_d.s1 = ~pin_n;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
  end

  // State register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  // Level and inactive-to-active pulse
  assign active = st_q.s2;
  assign activated = st_q.s2 & ~st_q.s3;
endmodule

// >>> hw/wdt_event_ctrl.sv
/*
  Watchdog event control: halt, software event message request, NMI
  redirect and force, alert pin gating, intrusion action and reboot.
  Assumes same-clock pulses from the timer, NMI source and message sender;
  RESETN is the core-well reset, RESUME_RESETN the resume-well reset.
*/
`timescale 1ns/1ps
module wdt_event_ctrl
  import wdt_ctrl_pkg::*;
#(
  parameter int REBOOT_LEN = REBOOT_CYCLES
)
(
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire logic RESUME_RESETN,
  input wire logic [7:0] IO_ADDR,
  input wire logic [1:0] IO_BE,
  input wire logic IO_WR,
  input wire logic IO_RD,
  input wire logic [15:0] IO_WDATA,
  output logic [15:0] IO_RDATA,
  input wire logic TIMEOUT2,
  input wire logic NO_REBOOT,
  input wire logic CLEAR_SECOND_TIMEOUT,
  input wire logic NMI_EVENT,
  input wire logic NMI_BLOCK,
  input wire logic GLOBAL_SMI_ENABLE,
  input wire logic MSG_DONE,
  input wire logic HEARTBEAT_DUE,
  input wire logic ALERT_PIN_N,
  input wire logic INTRUDER_N,
  output logic TIMER_RUN,
  output logic MSG_REQ,
  output logic MSG_SW_EVENT,
  output logic HEARTBEAT_REQ,
  output logic LAN_RESET,
  output logic NMI_OUT,
  output logic SMI_OUT,
  output logic IRQ_OUT,
  output logic ALERT_ACTIVE,
  output logic SECOND_TIMEOUT_FLAG,
  output logic PCI_RESET_N
);
  typedef struct packed {
    logic halt;
    logic send_req;
    logic nmi_redirect;
    logic force_nmi;
    logic msg_req;
    logic msg_sw;
    logic evt_pending;
    logic heartbeat;
    logic lan_rst;
    logic nmi_out;
    logic smi_out;
    logic irq_out;
    logic alert_act;
    logic sec_to;
    logic run;
    logic [REBOOT_CNT_W-1:0] rst_cnt;
    logic pci_rst_n;
    logic [15:0] rdata;
  } core_t;

  typedef struct packed {
    logic alert_dis;
    logic [1:0] intr_sel;
  } resume_t;

  core_t cq, cd;
  resume_t rq, rd;
  logic alert_on;
  logic intr_rise;
  logic wr_hi1, wr_lo2, rd_hit1, rd_hit2;
  logic send_wr, force_wr, nmi_any, tmo;

  // Pin synchronisers
  pin_edge_sync u_alert_sync (
    .clk(CLK_SYS),
    .rst_n(RESETN),
    .pin_n(ALERT_PIN_N),
    .active(alert_on),
    .activated()
  );

  pin_edge_sync u_intr_sync (
    .clk(CLK_SYS),
    .rst_n(RESETN),
    .pin_n(INTRUDER_N),
    .active(),
    .activated(intr_rise)
  );

  // Register decode; low byte of first register is all reserved
  assign wr_hi1 = IO_WR & (IO_ADDR == OFF_WDT_NMI_CTRL) & IO_BE[1];
  assign wr_lo2 = IO_WR & (IO_ADDR == OFF_ALERT_INTR_CTRL) & IO_BE[0];
  assign rd_hit1 = IO_ADDR == OFF_WDT_NMI_CTRL;
  assign rd_hit2 = IO_ADDR == OFF_ALERT_INTR_CTRL;
  assign send_wr = wr_hi1 & IO_WDATA[BIT_SEND_REQ];
  assign force_wr = wr_hi1 & IO_WDATA[BIT_FORCE_NMI];
  assign nmi_any = NMI_EVENT | (force_wr & ~cq.force_nmi);
  assign tmo = TIMEOUT2 & ~cq.halt;

  // Resume-well register next state
  always_comb
  begin
    rd = rq;
    if (wr_lo2)
    begin
      rd.alert_dis = IO_WDATA[BIT_ALERT_DISABLE];
      rd.intr_sel = IO_WDATA[BIT_INTR_SEL_LO +: 2];
    end
  end

  // Resume-well register, preset on resume reset
  always_ff @(posedge CLK_SYS or negedge RESUME_RESETN)
  begin
    if (!RESUME_RESETN)
    begin
      rq.alert_dis <= RST_ALERT_INTR_CTRL[BIT_ALERT_DISABLE];
      rq.intr_sel <= RST_ALERT_INTR_CTRL[BIT_INTR_SEL_LO +: 2];
    end
    else
      rq <= rd;
  end

  // Core-well next state
  always_comb
  begin
    cd = cq;
    cd.lan_rst = 1'b0;
    cd.nmi_out = 1'b0;
    cd.smi_out = 1'b0;
    cd.irq_out = 1'b0;
    // Plain control bits; reserved bits are dropped
    if (wr_hi1)
    begin
      cd.halt = IO_WDATA[BIT_TIMER_HALT];
      cd.nmi_redirect = IO_WDATA[BIT_NMI_REDIRECT];
    end
    // Send request: set by write, refused while halted
    if (send_wr & ~cq.send_req & ~cq.halt)
    begin
      cd.send_req = 1'b1;
      cd.lan_rst = 1'b1;
    end
    // Message sender: software request first, then timeout event
    if (cq.msg_req)
    begin
      if (MSG_DONE)
      begin
        cd.msg_req = 1'b0;
        if (cq.msg_sw)
          cd.send_req = 1'b0;
      end
    end
    else if (cq.send_req)
    begin
      cd.msg_req = 1'b1;
      cd.msg_sw = 1'b1;
    end
    else if (cq.evt_pending & ~cq.halt)
    begin
      cd.msg_req = 1'b1;
      cd.msg_sw = 1'b0;
      cd.evt_pending = 1'b0;
    end
    // Halt discards queued event messages
    if (cq.halt)
      cd.evt_pending = 1'b0;
    else if (tmo)
      cd.evt_pending = 1'b1;
    // Heartbeats pass regardless of halt
    cd.heartbeat = HEARTBEAT_DUE;
    // Force NMI: write one toggles, set only when clear
    if (force_wr)
      cd.force_nmi = ~cq.force_nmi;
    // NMI delivery or redirect
    if (nmi_any)
    begin
      if (cq.nmi_redirect)
        cd.smi_out = ~NMI_BLOCK & GLOBAL_SMI_ENABLE;
      else
        cd.nmi_out = 1'b1;
    end
    // Intrusion action on each activation
    if (intr_rise)
    begin
      unique case (rq.intr_sel)
        INTR_IRQ: cd.irq_out = 1'b1;
        INTR_SMI: cd.smi_out = 1'b1;
        default: ;
      endcase
    end
    // Alert pin gated by disable bit
    cd.alert_act = alert_on & ~rd.alert_dis;
    // Second timeout flag; set wins over clear
    if (tmo)
      cd.sec_to = 1'b1;
    else if (CLEAR_SECOND_TIMEOUT)
      cd.sec_to = 1'b0;
    // Reboot pulse
    if (tmo & ~NO_REBOOT)
      cd.rst_cnt = REBOOT_CNT_W'(REBOOT_LEN);
    else if (cq.rst_cnt != '0)
      cd.rst_cnt = cq.rst_cnt - 1'b1;
    cd.pci_rst_n = (cd.rst_cnt == '0);
    cd.run = ~cd.halt;
    // Read data, reserved positions zero
    cd.rdata = '0;
    if (IO_RD & rd_hit1)
    begin
      cd.rdata[BIT_TIMER_HALT] = cq.halt;
      cd.rdata[BIT_SEND_REQ] = cq.send_req;
      cd.rdata[BIT_NMI_REDIRECT] = cq.nmi_redirect;
      cd.rdata[BIT_FORCE_NMI] = cq.force_nmi;
    end
    else if (IO_RD & rd_hit2)
    begin
      cd.rdata[BIT_ALERT_DISABLE] = rq.alert_dis;
      cd.rdata[BIT_INTR_SEL_LO +: 2] = rq.intr_sel;
    end
  end

  // Core-well state register
  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      cq <= '0;
      cq.run <= 1'b1;
      cq.pci_rst_n <= 1'b1;
    end
    else
      cq <= cd;
  end

  // Outputs straight from flops
  assign IO_RDATA = cq.rdata;
  assign TIMER_RUN = cq.run;
  assign MSG_REQ = cq.msg_req;
  assign MSG_SW_EVENT = cq.msg_sw;
  assign HEARTBEAT_REQ = cq.heartbeat;
  assign LAN_RESET = cq.lan_rst;
  assign NMI_OUT = cq.nmi_out;
  assign SMI_OUT = cq.smi_out;
  assign IRQ_OUT = cq.irq_out;
  assign ALERT_ACTIVE = cq.alert_act;
  assign SECOND_TIMEOUT_FLAG = cq.sec_to;
  assign PCI_RESET_N = cq.pci_rst_n;

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESETN);

  // Software send request accepted while idle
  sequence send_accept_s;
    send_wr && !cq.send_req && !cq.halt && !cq.msg_req && !cq.evt_pending && !tmo;
  endsequence
  sequence send_launch_s;
    ##2 (MSG_REQ && MSG_SW_EVENT);
  endsequence

  chk_halt_stops_timer: assert property (wr_hi1 && IO_WDATA[BIT_TIMER_HALT] |=> !TIMER_RUN)
    else $error("timer still runs after halt");
  chk_halt_no_reboot: assert property (cq.halt && PCI_RESET_N |=> PCI_RESET_N)
    else $error("reboot while halted");
  chk_send_message: assert property (send_accept_s |-> send_launch_s)
    else $error("software event message not started");
  chk_send_clears: assert property (MSG_REQ && MSG_SW_EVENT && MSG_DONE |=> !cq.send_req && !MSG_REQ)
    else $error("send request not cleared");
  chk_lan_reset: assert property (send_accept_s |=> LAN_RESET)
    else $error("no network reset on send");
  chk_nmi_plain: assert property (NMI_EVENT && !cq.nmi_redirect |=> NMI_OUT)
    else $error("NMI not delivered");
  chk_nmi_redirect: assert property (NMI_EVENT && cq.nmi_redirect && !intr_rise |=> !NMI_OUT
      && (SMI_OUT == ($past(GLOBAL_SMI_ENABLE) && !$past(NMI_BLOCK))))
    else $error("redirected NMI wrong");
  chk_force_toggle: assert property (force_wr && cq.force_nmi |=> !cq.force_nmi)
    else $error("force bit not cleared");
  chk_alert_gate: assert property (rq.alert_dis && !wr_lo2 |=> !ALERT_ACTIVE)
    else $error("alert passed while disabled");
  chk_intr_smi: assert property (intr_rise && rq.intr_sel == INTR_SMI |=> SMI_OUT)
    else $error("intrusion SMI missing");
  chk_reserved_zero: assert property (IO_RD && rd_hit1 |=> IO_RDATA[7:0] == 8'h00 && IO_RDATA[15:12] == 4'h0)
    else $error("reserved bits not zero");
  chk_second_timeout: assert property (tmo && !NO_REBOOT |=> SECOND_TIMEOUT_FLAG && !PCI_RESET_N)
    else $error("second timeout not handled");
  chk_resume_preset: assert property (@(posedge CLK_SYS) disable iff (!RESUME_RESETN)
      $rose(RESUME_RESETN) |-> rq.alert_dis)
    else $error("alert disable not preset");
endmodule

// >>> include/wdt_ctrl_pkg.sv
/*
  Constants for the watchdog event control block: register offsets, field
  positions, reset values and timing counts.
  Assumes a 10 MHz system clock and a 16-bit I/O register window.
*/
//
// Contract
// - Halt bit stops the watchdog timer counting
// - Halt blocks reboot and events, not heartbeats
// - Send request transmits one software event message
// - Send request bit clears when transmission finishes
// - Setting send request also resets network controller
// - Redirect enable routes NMI events to SMI
// - Redirected NMI gives SMI only if unblocked, enabled
// - Writing force bit generates one NMI
// - Force bit set: no repeat; write one clears
// - Alert disable ignores alert pin as source
// - Resume reset sets alert disable bit
// - Intrusion action field: none, interrupt, SMI, reserved
// - Registers reset to zero except alert disable; reserved bits defined
// - Second timeout without no-reboot sets flag, reboots
package wdt_ctrl_pkg;
  // I/O offsets within the watchdog window
  localparam logic [7:0] OFF_WDT_NMI_CTRL = 8'h08;
  localparam logic [7:0] OFF_ALERT_INTR_CTRL = 8'h0a;
  // Field positions
  localparam int BIT_TIMER_HALT = 11;
  localparam int BIT_SEND_REQ = 10;
  localparam int BIT_NMI_REDIRECT = 9;
  localparam int BIT_FORCE_NMI = 8;
  localparam int BIT_ALERT_DISABLE = 3;
  localparam int BIT_INTR_SEL_LO = 1;
  // Reset values
  localparam logic [15:0] RST_WDT_NMI_CTRL = 16'h0000;
  localparam logic [15:0] RST_ALERT_INTR_CTRL = 16'h0008;
  // Intrusion action encodings
  localparam logic [1:0] INTR_NONE = 2'h0;
  localparam logic [1:0] INTR_IRQ = 2'h1;
  localparam logic [1:0] INTR_SMI = 2'h2;
  // Reboot pulse timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int REBOOT_PULSE_NS = 1000;
  localparam int REBOOT_CYCLES = (REBOOT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REBOOT_CNT_W = 4;
endpackage

// >>> test/link_receiver_model.sv
/*
  Management link receiver model: takes each held message request and
  answers it with a one-cycle done pulse after a chosen number of cycles.
  Assumes the request stays high until done is seen, then drops.
*/
`timescale 1ns/1ps
module link_receiver_model
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic msg_req,
  input wire logic [3:0] delay,
  output logic msg_done
);
  logic [3:0] cnt_q;

  // Count the wait, pulse done once, park until the request drops
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= 4'h0;
      msg_done <= 1'b0;
    end
    else
    begin
      msg_done <= 1'b0;
      if (!msg_req)
        cnt_q <= 4'h0;
      else if (cnt_q == delay)
      begin
        msg_done <= 1'b1;
        cnt_q <= 4'hf;
      end
      else if (cnt_q != 4'hf)
        cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule

// >>> test/testbench.sv
/*
  Self-checking bench for the watchdog event control block.
  Assumes inputs change at the falling edge and outputs settle by then.
*/
`timescale 1ns/1ps
module testbench;
  import wdt_ctrl_pkg::*;
  localparam int RLEN = 3;
  logic clk_sys = 1'b0, resetn = 1'b0, resume_resetn = 1'b0;
  logic [7:0] io_addr = 8'h00;
  logic [1:0] io_be = 2'h0;
  logic io_wr = 1'b0, io_rd = 1'b0, timeout2 = 1'b0, no_reboot = 1'b0, clr_flag = 1'b0;
  logic nmi_event = 1'b0, nmi_block = 1'b0, gsmi = 1'b0, msg_done, hb_due = 1'b0;
  logic alert_n = 1'b0, intr_n = 1'b1;
  logic [15:0] io_wdata = 16'h0000;
  logic [3:0] link_delay = 4'h0;
  logic [15:0] io_rdata;
  logic run, req, swev, hb, lanrst, nmi, smi, irq, alert, flag, pci_reset_n_n;
  int errors = 0, compares = 0, n_irq, n_smi;

  wdt_event_ctrl #(.REBOOT_LEN(RLEN)) u_wdt_event_ctrl (.CLK_SYS(clk_sys), .RESETN(resetn),
    .RESUME_RESETN(resume_resetn), .IO_ADDR(io_addr), .IO_BE(io_be), .IO_WR(io_wr), .IO_RD(io_rd),
    .IO_WDATA(io_wdata), .IO_RDATA(io_rdata), .TIMEOUT2(timeout2), .NO_REBOOT(no_reboot),
    .CLEAR_SECOND_TIMEOUT(clr_flag), .NMI_EVENT(nmi_event), .NMI_BLOCK(nmi_block),
    .GLOBAL_SMI_ENABLE(gsmi), .MSG_DONE(msg_done), .HEARTBEAT_DUE(hb_due), .ALERT_PIN_N(alert_n),
    .INTRUDER_N(intr_n), .TIMER_RUN(run), .MSG_REQ(req), .MSG_SW_EVENT(swev), .HEARTBEAT_REQ(hb),
    .LAN_RESET(lanrst), .NMI_OUT(nmi), .SMI_OUT(smi), .IRQ_OUT(irq), .ALERT_ACTIVE(alert),
    .SECOND_TIMEOUT_FLAG(flag), .PCI_RESET_N(pci_reset_n_n));
  link_receiver_model u_link_receiver_model (.clk(clk_sys), .rst_n(resetn), .msg_req(req),
    .delay(link_delay), .msg_done(msg_done));

  // Clock
  initial
  begin
    forever #50 clk_sys = ~clk_sys;
  end

  task check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task end_sim;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task wr(input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
    @(negedge clk_sys);
    io_addr = a;
    io_be = be;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge clk_sys);
    io_wr = 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [15:0] exp);
    @(negedge clk_sys);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge clk_sys);
    io_rd = 1'b0;
    check(io_rdata, exp);
  endtask

  task t_regs;
    rd(8'h08, 16'h0000);
    rd(8'h0a, 16'h0008);
    rd(8'h0c, 16'h0000);
    wr(8'h08, 2'b10, 16'hf0ff);
    rd(8'h08, 16'h0000);
    wr(8'h0a, 2'b01, 16'hfff7);
    rd(8'h0a, 16'h0006);
  endtask

  task t_halt;
    wr(8'h08, 2'b10, 16'h0800);
    check(run, 1'b0);
    hb_due = 1'b1;
    timeout2 = 1'b1;
    @(negedge clk_sys);
    hb_due = 1'b0;
    timeout2 = 1'b0;
    check(hb, 1'b1);
    repeat (3)
    begin
      @(negedge clk_sys);
      check({flag, pci_reset_n_n, req}, 3'b010);
    end
    wr(8'h08, 2'b10, 16'h0000);
    check(run, 1'b1);
  endtask

  task t_send(input logic [3:0] dly);
    link_delay = dly;
    wr(8'h08, 2'b10, 16'h0400);
    check(lanrst, 1'b1);
    @(negedge clk_sys);
    check({req, swev}, 2'b11);
    for (int i = 0; i < 20 && req; i++)
      @(negedge clk_sys);
    check(req, 1'b0);
    rd(8'h08, 16'h0000); // next send only after bit clears
  endtask

  task t_redirect;
    wr(8'h08, 2'b10, 16'h0200);
    nmi_event = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      {nmi_block, gsmi} = i[1:0];
      @(negedge clk_sys);
      check({nmi, smi}, {1'b0, !nmi_block && gsmi});
    end
    nmi_event = 1'b0;
    wr(8'h08, 2'b10, 16'h0000);
    nmi_event = 1'b1;
    @(negedge clk_sys);
    nmi_event = 1'b0;
    check({nmi, smi}, 2'b10);
  endtask

  task t_force;
    wr(8'h08, 2'b10, 16'h0100);
    check(nmi, 1'b1);
    rd(8'h08, 16'h0100);
    check(nmi, 1'b0);
    wr(8'h08, 2'b10, 16'h0100); // handler clears it
    check(nmi, 1'b0);
    rd(8'h08, 16'h0000);
  endtask

  task t_alert_intr;
    wr(8'h0a, 2'b01, 16'h0008);
    repeat (4) @(negedge clk_sys);
    check(alert, 1'b0);
    for (int s = 0; s < 4; s++)
    begin
      wr(8'h0a, 2'b01, 16'(s * 2));
      {n_irq, n_smi} = 0;
      intr_n = 1'b0;
      repeat (10)
      begin
        @(negedge clk_sys);
        n_irq += irq;
        n_smi += smi;
      end
      check(16'(n_irq), 16'(s == 1));
      check(16'(n_smi), 16'(s == 2));
      intr_n = 1'b1;
      repeat (4) @(negedge clk_sys);
    end
    check(alert, 1'b1);
  endtask

  task t_reboot;
    link_delay = 4'h0;
    for (int r = 0; r < 2; r++)
    begin
      no_reboot = r[0];
      timeout2 = 1'b1;
      @(negedge clk_sys);
      timeout2 = 1'b0;
      check(flag, 1'b1);
      {n_irq, n_smi} = 0;
      repeat (12)
      begin
        n_irq += !pci_reset_n_n;
        n_smi += req && !swev;
        @(negedge clk_sys);
      end
      check(16'(n_irq), r ? 16'h0000 : 16'(RLEN));
      check(16'(n_smi), 16'h0002);
      clr_flag = 1'b1;
      @(negedge clk_sys);
      clr_flag = 1'b0;
      check(flag, 1'b0);
    end
  endtask

  task t_resets;
    wr(8'h08, 2'b10, 16'h0a00);
    wr(8'h0a, 2'b01, 16'h0004);
    resetn = 1'b0;
    @(negedge clk_sys);
    resetn = 1'b1;
    check({run, pci_reset_n_n, flag}, 3'b110);
    rd(8'h08, 16'h0000);
    rd(8'h0a, 16'h0004);
    resume_resetn = 1'b0;
    @(negedge clk_sys);
    resume_resetn = 1'b1;
    rd(8'h0a, 16'h0008);
  endtask

  // Watchdog against a hang
  initial
  begin
    #1000000;
    errors++;
    end_sim;
  end

  // Main sequence
  initial
  begin
    repeat (20) @(negedge clk_sys);
    resetn = 1'b1;
    resume_resetn = 1'b1;
    t_regs;
    t_halt;
    t_send(4'h6);
    t_send(4'h0);
    t_redirect;
    t_force;
    t_alert_intr;
    t_reboot;
    t_resets;
    end_sim;
  end
endmodule
